// file: rtl/qdl_dev.sv
/*
  Converter end: serial input register, per-channel holding latches and outputs.
  Assumes the link pins come from another clock domain and are resynchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - Shift one bit per serial clock fall
// R2 - Latch strobe low moves word to channel
// R3 - Update strobe low: output follows immediately
// R4 - Update strobe high: hold until strobe falls
// R5 - Word travels most significant bit first
// R6 - Select 00/01/10/11 picks channels A..D
// R7 - Range bit doubles the output span
// R8 - Host may send an eight-bit burst then three bits
// R9 - Latch strobe falls after eleventh bit
// R10 - Latch strobe low at least 250 ns
// R11 - Update strobe low at least 250 ns
// R12 - Order: select hi, lo, range, code
// R13 - Power-up clears every channel code
// R14 - Code is unsigned, 256 steps of span
module qdl_dev
  import qdl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link
  qdl_if.dev link,
  // Channel outputs (code and range per channel)
  output logic [`QDL_CODE_BITS-1:0] o_channel_a_output,
  output logic [`QDL_CODE_BITS-1:0] o_channel_b_output,
  output logic [`QDL_CODE_BITS-1:0] o_channel_c_output,
  output logic [`QDL_CODE_BITS-1:0] o_channel_d_output,
  output logic [`QDL_NUM_CH-1:0] o_gain_range_bit,
  // Debug: bits shifted since latch strobe rose
  output logic [3:0] o_bit_count
);
  // Channel decode used for both holding latch and output writes
  function automatic logic [`QDL_NUM_CH-1:0] chan_onehot(input qdl_chan_t sel);
    chan_onehot = `QDL_NUM_CH'(1) << sel; // see R6
  endfunction

  logic [1:0] sclk_sync_ff, sdata_sync_ff, load_sync_ff, upd_sync_ff;
  logic sclk_q_ff, load_q_ff, upd_q_ff;
  qdl_word_t shift_ff, nxt_shift;
  logic [3:0] cnt_ff, nxt_cnt;
  qdl_code_t hold_code_ff [`QDL_NUM_CH];
  qdl_code_t out_code_ff [`QDL_NUM_CH];
  logic [`QDL_NUM_CH-1:0] hold_rng_ff, out_rng_ff;

  // Two-stage synchronisers; only the second stage is read by logic
  always_ff @(posedge i_clk) begin
    sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
    sdata_sync_ff <= {sdata_sync_ff[0], link.sdata};
    load_sync_ff <= {load_sync_ff[0], link.load};
    upd_sync_ff <= {upd_sync_ff[0], link.output_update_strobe};
  end

  // Edge history of the synchronised levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sclk_q_ff <= 1'b1;
      load_q_ff <= 1'b1;
      upd_q_ff <= 1'b0; // Update strobe idles low after reset; avoids a false fall
    end else begin
      sclk_q_ff <= sclk_sync_ff[1];
      load_q_ff <= load_sync_ff[1];
      upd_q_ff <= upd_sync_ff[1];
    end
  end

  wire sclk_fall = sclk_q_ff & ~sclk_sync_ff[1];
  wire load_fall = load_q_ff & ~load_sync_ff[1];
  wire upd_fall = upd_q_ff & ~upd_sync_ff[1];
  wire load_high = load_sync_ff[1];
  wire upd_low = ~upd_sync_ff[1];
  // Channel fields of the captured word
  wire qdl_chan_t word_sel = {shift_ff[`QDL_SEL_HI_POS], shift_ff[`QDL_SEL_LO_POS]}; // see R12
  wire word_rng = shift_ff[`QDL_RANGE_POS];
  wire qdl_code_t word_code = shift_ff[`QDL_CODE_MSB_POS:0];
  wire [`QDL_NUM_CH-1:0] sel_hot = chan_onehot(word_sel);

  // Shifting: counter does not wrap, so bursts of eight need no special case (see R8)
  assign nxt_shift = (sclk_fall && load_high) ? {shift_ff[`QDL_WORD_BITS-2:0], sdata_sync_ff[1]} : shift_ff; // see R1
  assign nxt_cnt = !load_high ? 4'h0 :
                   (sclk_fall && cnt_ff != 4'hF) ? cnt_ff + 4'h1 : cnt_ff;

  // Serial input register; newest bit enters at the bottom so the first bit ends on top
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      shift_ff <= '0;
      cnt_ff <= 4'h0;
    end else begin
      shift_ff <= nxt_shift; // see R5
      cnt_ff <= nxt_cnt;
    end
  end

  // Holding latches and outputs per channel; only the last 11 bits count if more arrive
  genvar g;
  generate
    for (g = 0; g < `QDL_NUM_CH; g++) begin : g_ch
      wire take = load_fall & sel_hot[g]; // see R2
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          hold_code_ff[g] <= `QDL_CODE_RESET; // see R13
          hold_rng_ff[g] <= 1'b0;
          out_code_ff[g] <= `QDL_CODE_RESET;
          out_rng_ff[g] <= 1'b0;
        end else begin
          if (take) begin
            hold_code_ff[g] <= word_code;
            hold_rng_ff[g] <= word_rng;
          end
          if (take && upd_low) begin
            out_code_ff[g] <= word_code; // see R3
            out_rng_ff[g] <= word_rng; // see R7
          end else if (upd_fall) begin
            out_code_ff[g] <= hold_code_ff[g]; // see R4
            out_rng_ff[g] <= hold_rng_ff[g];
          end
        end
      end
    end
  endgenerate

  // Codes are unsigned 0..255, one step per 1/256 of span (see R14)
  assign o_channel_a_output = out_code_ff[0];
  assign o_channel_b_output = out_code_ff[1];
  assign o_channel_c_output = out_code_ff[2];
  assign o_channel_d_output = out_code_ff[3];
  assign o_gain_range_bit = out_rng_ff;
  assign o_bit_count = cnt_ff;
endmodule

`default_nettype wire

// file: rtl/qdl_consts.svh
/*
  Timing counts and word layout constants for the quad converter serial load link.
  Assumes a 250 MHz system clock on both ends.
*/
`ifndef QDL_CONSTS_SVH
`define QDL_CONSTS_SVH

`define QDL_CLK_PERIOD_NS 4
`define QDL_WORD_BITS 11
`define QDL_CODE_BITS 8
`define QDL_NUM_CH 4
`define QDL_SEL_HI_POS 10
`define QDL_SEL_LO_POS 9
`define QDL_RANGE_POS 8
`define QDL_CODE_MSB_POS 7
`define QDL_CODE_RESET 8'h00
`define QDL_STROBE_LOW_NS 250
`define QDL_STROBE_LOW_CYC ((`QDL_STROBE_LOW_NS + `QDL_CLK_PERIOD_NS - 1) / `QDL_CLK_PERIOD_NS)
`define QDL_SETUP_NS 50
`define QDL_SETUP_CYC ((`QDL_SETUP_NS + `QDL_CLK_PERIOD_NS - 1) / `QDL_CLK_PERIOD_NS)
`define QDL_SCLK_HALF_CYC 125
`define QDL_BURST_BITS 8

`endif

// file: rtl/qdl_pkg.sv
/*
  Types shared by both ends of the quad converter serial load link.
  Assumes qdl_consts.svh supplies the numeric layout.
*/
`include "qdl_consts.svh"

package qdl_pkg;
  typedef logic [`QDL_WORD_BITS-1:0] qdl_word_t;
  typedef logic [`QDL_CODE_BITS-1:0] qdl_code_t;
  typedef logic [1:0] qdl_chan_t;
endpackage

// file: rtl/qdl_if.sv
/*
  Three-wire serial link plus output update strobe between host and converter.
  Assumes the host drives every wire; the converter only listens.
*/
`timescale 1ns/1ps
`default_nettype none

interface qdl_if;
  logic sclk;
  logic sdata;
  logic load;
  logic output_update_strobe;

  // Host drives all wires
  modport host (output sclk, output sdata, output load, output output_update_strobe);
  // Converter samples all wires
  modport dev (input sclk, input sdata, input load, input output_update_strobe);
endinterface

`default_nettype wire

// file: rtl/qdl_host.sv
/*
  Host end: sends one 11-bit command as two bursts and pulses the strobes.
  Assumes a single 250 MHz clock; the serial clock is divided from it.
*/
`timescale 1ns/1ps
`default_nettype none

module qdl_host
  import qdl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Command request
  input wire logic i_req,
  input wire logic [1:0] i_chan,
  input wire logic i_range,
  input wire logic [`QDL_CODE_BITS-1:0] i_code,
  input wire logic i_hold,
  input wire logic i_update,
  output logic o_ready,
  // Link
  qdl_if.host link
);
  typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_GAP, ST_LATCH, ST_UPD} qdl_hstate_t;
  localparam int HALF = `QDL_SCLK_HALF_CYC;
  localparam int PULSE = `QDL_STROBE_LOW_CYC;

  qdl_hstate_t st_ff, nxt_st;
  logic [15:0] tmr_ff;
  logic [3:0] bits_ff;
  qdl_word_t word_ff;
  logic hold_ff, sclk_ff;

  wire tmr_done = (tmr_ff == 16'h0000);
  wire burst_edge = (bits_ff == 4'(`QDL_BURST_BITS));

  // Sequencing; latch strobe only falls after the eleventh clock fall (see R9)
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (i_update) nxt_st = ST_UPD; else if (i_req) nxt_st = ST_SETUP;
      ST_SETUP: if (tmr_done) nxt_st = ST_HIGH;
      ST_HIGH: if (tmr_done) nxt_st = ST_LOW;
      ST_LOW: if (tmr_done) nxt_st = (bits_ff == 4'(`QDL_WORD_BITS)) ? ST_LATCH : (burst_edge ? ST_GAP : ST_HIGH);
      ST_GAP: if (tmr_done) nxt_st = ST_HIGH; // see R8
      ST_LATCH: if (tmr_done) nxt_st = ST_IDLE;
      ST_UPD: if (tmr_done) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Datapath and timers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= ST_IDLE;
      tmr_ff <= 16'h0000;
      bits_ff <= 4'h0;
      word_ff <= '0;
      hold_ff <= 1'b0;
      sclk_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= tmr_done ? 16'h0000 : tmr_ff - 16'h0001;
      if (st_ff == ST_IDLE && i_update) begin
        tmr_ff <= 16'(PULSE); // see R11
      end else if (st_ff == ST_IDLE && i_req) begin
        word_ff <= {i_chan, i_range, i_code}; // see R12
        hold_ff <= i_hold;
        bits_ff <= 4'h0;
        tmr_ff <= 16'(`QDL_SETUP_CYC);
      end else if (nxt_st != st_ff) begin
        case (nxt_st)
          ST_HIGH: begin
            sclk_ff <= 1'b1;
            tmr_ff <= 16'(HALF);
          end
          ST_LOW: begin
            sclk_ff <= 1'b0;
            bits_ff <= bits_ff + 4'h1;
            tmr_ff <= 16'(HALF);
          end
          ST_GAP: tmr_ff <= 16'(HALF);
          // Clock returns high on the same clock edge that the latch strobe falls, so it idles high between words
          ST_LATCH: begin
            sclk_ff <= 1'b1;
            tmr_ff <= 16'(PULSE); // see R10
          end
          default: tmr_ff <= 16'h0000;
        endcase
        // Next bit appears as the clock rises, after a low phase or the burst gap alike (see R8)
        if (nxt_st == ST_HIGH && st_ff != ST_SETUP) begin
          word_ff <= {word_ff[`QDL_WORD_BITS-2:0], 1'b0}; // see R5
        end
      end
    end
  end

  // Pins: data is the top bit, stable across each falling edge (see R1)
  assign link.sclk = sclk_ff;
  assign link.sdata = word_ff[`QDL_WORD_BITS-1];
  assign link.load = (st_ff != ST_LATCH); // see R2
  assign link.output_update_strobe = (st_ff == ST_UPD) ? 1'b0 : hold_ff; // see R3 R4
  assign o_ready = (st_ff == ST_IDLE);
endmodule

`default_nettype wire

// file: dv/qdl_link_monitor.sv
/* Checker of the serial load wires between the host and converter ends.
   Assumes every wire is sampled on the shared system clock. */
`timescale 1ns/1ps
`default_nettype none
module qdl_link_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link wires
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load,
  input wire logic output_update_strobe
);
  logic [6:0] ld_lo_ff;
  logic [6:0] up_lo_ff;
  logic [3:0] falls_ff;
  logic sclk_q_ff;
  // Low-time counters saturate and restart full, so a strobe low out of reset is no short pulse
  always_ff @(posedge i_clk) begin
    ld_lo_ff <= (!i_rst_n) ? 7'h7F : (load ? 7'h00 : ld_lo_ff + 7'(ld_lo_ff != 7'h7F));
    up_lo_ff <= (!i_rst_n) ? 7'h7F : (output_update_strobe ? 7'h00 : up_lo_ff + 7'(up_lo_ff != 7'h7F));
  end
  // Serial clock falls seen while the latch strobe is high
  always_ff @(posedge i_clk) begin
    sclk_q_ff <= sclk;
    falls_ff <= (!i_rst_n || !load) ? 4'h0 : falls_ff + 4'(sclk_q_ff && !sclk);
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_load_width; $rose(load) |-> ld_lo_ff >= 7'h3F; endproperty
  a_load_width: assert property (p_load_width) else $error("latch strobe pulse too short");
  property p_upd_width; $rose(output_update_strobe) |-> up_lo_ff >= 7'h3F; endproperty
  a_upd_width: assert property (p_upd_width) else $error("update strobe pulse too short");
  property p_bit_count; $fell(load) |-> falls_ff == 4'hB; endproperty
  a_bit_count: assert property (p_bit_count) else $error("word not eleven bits");
  property p_data_valid; !sclk && !$past(sclk) |-> $stable(sdata); endproperty
  a_data_valid: assert property (p_data_valid) else $error("data moved while clock low");
  property p_clk_idle; !load |-> sclk; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("serial clock low during latch");
  property p_load_setup; $rose(load) |-> sclk [*8]; endproperty
  a_load_setup: assert property (p_load_setup) else $error("clock fell too soon after latch");
  property p_low_phase; $fell(sclk) |-> !sclk [*8]; endproperty
  a_low_phase: assert property (p_low_phase) else $error("serial clock low phase too short");
  property p_upd_idle; $fell(output_update_strobe) |-> load; endproperty
  a_upd_idle: assert property (p_upd_idle) else $error("update strobe fell during latch");
endmodule
`default_nettype wire

// file: dv/quad_dac_serial_load_interface_tb.sv
/* Bench joining host and converter ends over the serial link, with a model of the outputs.
   Assumes the checker watches the link and the host paces the wire itself. */
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_interface_tb;
  import qdl_pkg::*;
  logic i_clk, i_rst_n, req, gain_range_bit, hold, upd, rdy;
  logic [1:0] chan;
  qdl_code_t code, a, b, c, d;
  logic [3:0] rngs;
  logic [8:0] lat [4];
  logic [8:0] outv [4];
  logic [8:0] dev_v [4];
  logic [7:0] corner [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
  int error_cnt = 0;
  int checks = 0;
  qdl_if link ();
  qdl_host u_qdl_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_chan(chan), .i_range(gain_range_bit),
    .i_code(code), .i_hold(hold), .i_update(upd), .o_ready(rdy), .link(link.host));
  qdl_dev u_qdl_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link.dev), .o_channel_a_output(a),
    .o_channel_b_output(b), .o_channel_c_output(c), .o_channel_d_output(d), .o_gain_range_bit(rngs),
    .o_bit_count());
  qdl_link_monitor u_qdl_link_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n), .sclk(link.sclk),
    .sdata(link.sdata), .load(link.load), .output_update_strobe(link.output_update_strobe));
  // Range bit above code, per channel
  assign dev_v[0] = {rngs[0], a};
  assign dev_v[1] = {rngs[1], b};
  assign dev_v[2] = {rngs[2], c};
  assign dev_v[3] = {rngs[3], d};
  function automatic logic [8:0] word_of(input logic rg, input logic [7:0] cd);
    return {rg, cd};
  endfunction
  task automatic stop_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Ready is sampled on the falling edge so it never races the launching edge
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge i_clk);
    while (rdy !== 1'b1 && n < 6000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 6000) error_cnt++;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic send(input logic [1:0] ch, input logic rg, input logic [7:0] cd, input logic hd);
    @(posedge i_clk);
    req <= 1'b1;
    chan <= ch;
    gain_range_bit <= rg;
    code <= cd;
    hold <= hd;
    @(posedge i_clk);
    req <= 1'b0;
    lat[ch] = word_of(rg, cd);
    if (!hd) outv = lat;
    wait_idle();
  endtask
  // Host drops ready for the whole pulse; still give the full pulse time first
  task automatic pulse_update();
    @(posedge i_clk);
    upd <= 1'b1;
    @(posedge i_clk);
    upd <= 1'b0;
    outv = lat;
    repeat (80) @(posedge i_clk);
    wait_idle();
  endtask
  task automatic check_all();
    for (int k = 0; k < 4; k++) begin
      checks++;
      if (dev_v[k] !== outv[k]) begin
        error_cnt++;
        $display("mismatch at %0t: got %h exp %h", $time, dev_v[k], outv[k]);
      end
    end
  endtask
  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      lat[k] = 9'h000;
      outv[k] = 9'h000;
    end
    wait_idle();
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    i_rst_n = 1'b0;
    req = 1'b0;
    chan = 2'h0;
    gain_range_bit = 1'b0;
    code = 8'h00;
    hold = 1'b0;
    upd = 1'b0;
    void'($urandom(32'hEED58050));
    do_reset();
    check_all();
    // Every select code with codes 00, FF, 80 and 01, outputs following at once
    for (int k = 0; k < 4; k++) begin
      send(k[1:0], k[0], corner[k], 1'b0);
      check_all();
    end
    // Held values, one channel written twice, stay out until the update pulse
    send(2'h2, 1'b1, 8'hA5, 1'b1);
    send(2'h1, 1'b0, 8'h3C, 1'b1);
    send(2'h2, 1'b0, 8'h5A, 1'b1);
    check_all();
    pulse_update();
    check_all();
    for (int k = 0; k < 10; k++) begin
      send(2'($urandom), 1'($urandom), 8'($urandom), 1'($urandom));
      check_all();
    end
    pulse_update();
    check_all();
    // A second reset in mid-run must clear every channel again
    do_reset();
    check_all();
    stop_test();
  end
endmodule
`default_nettype wire
